// ==== common/reload_timer_pkg.sv ====
// package: register map, field positions, reset values and timing counts
package reload_timer_pkg;

  // register index map (byte address = index, 8-bit data port)
  localparam logic [3:0] REG_CTRL      = 4'h0; // mode, run, preset strobes
  localparam logic [3:0] REG_CLKSEL    = 4'h1; // source and ratio per channel
  localparam logic [3:0] REG_EVENT     = 4'h2; // event mode options
  localparam logic [3:0] REG_RELOAD0   = 4'h3; // reload value, channel 0
  localparam logic [3:0] REG_RELOAD1   = 4'h4; // reload value, channel 1
  localparam logic [3:0] REG_COUNT0_LO = 4'h5; // count nibble 0, ch 0
  localparam logic [3:0] REG_COUNT0_HI = 4'h6; // latched nibble 1, ch 0
  localparam logic [3:0] REG_COUNT1_LO = 4'h7; // count nibble 0, ch 1
  localparam logic [3:0] REG_COUNT1_HI = 4'h8; // latched nibble 1, ch 1
  localparam logic [3:0] REG_IRQ_EN    = 4'h9; // interrupt mask bits
  localparam logic [3:0] REG_IRQ_FLAG  = 4'hA; // flags, write 1 to clear
  localparam logic [3:0] REG_TOGGLE    = 4'hB; // toggle output control

  // REG_CTRL fields
  localparam int CTRL_WIDE    = 0;
  localparam int CTRL_RUN0    = 1;
  localparam int CTRL_RUN1    = 2;
  localparam int CTRL_PRESET0 = 3;
  localparam int CTRL_PRESET1 = 4;
  // REG_CLKSEL fields
  localparam int CLK_SRC0   = 0;
  localparam int CLK_RATIO0 = 1; // two bits
  localparam int CLK_SRC1   = 4;
  localparam int CLK_RATIO1 = 5; // two bits
  // REG_EVENT fields
  localparam int EV_MODE = 0;
  localparam int EV_POL  = 1;
  localparam int EV_NR   = 2;
  // REG_TOGGLE fields
  localparam int TG_CHAN = 0;
  localparam int TG_OE   = 1;

  // prescaler ratio codes
  localparam logic [1:0] RATIO_1   = 2'h0;
  localparam logic [1:0] RATIO_4   = 2'h1;
  localparam logic [1:0] RATIO_32  = 2'h2;
  localparam logic [1:0] RATIO_256 = 2'h3;
  localparam logic [7:0] DIV_MASK_4   = 8'h03;
  localparam logic [7:0] DIV_MASK_32  = 8'h1F;
  localparam logic [7:0] DIV_MASK_256 = 8'hFF;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [7:0] COUNT_ONE  = 8'h01;

  // noise rejector: two falling edges of the 2048 Hz tick
  localparam int NR_EDGES = 2;

  // bundled per-channel settings
  typedef struct packed {
    logic       src;   // 0 slow, 1 fast oscillator
    logic [1:0] ratio; // prescaler ratio code
  } clk_cfg_t;

endpackage

// ==== hdl/ratio_prescaler.sv ====
// prescaler: divides a source tick by 1, 4, 32 or 256 while running
`timescale 1ns/1ns
module ratio_prescaler
  import reload_timer_pkg::*;
(
  input  wire logic                       clk_sys,
  input  wire logic                       resetn,
  input  wire logic                       slow_tick,  // slow oscillator tick
  input  wire logic                       fast_tick,  // fast oscillator tick
  input  wire reload_timer_pkg::clk_cfg_t cfg,        // source and ratio
  input  wire logic                       run,        // counter running
  output logic                            count_pulse // one-cycle count
);
  import reload_timer_pkg::*;

  typedef struct packed {
    logic [7:0] div;   // free divider
    logic       pulse; // registered output pulse
  } pre_state_t;

  pre_state_t st_r;
  pre_state_t st_nxt;
  logic       src_tick; // selected source tick
  logic [7:0] mask;     // terminal mask for the ratio

  // next state: source only taken in while running
  always_comb begin
    st_nxt   = st_r;
    src_tick = cfg.src ? fast_tick : slow_tick;
    case (cfg.ratio)
      RATIO_4:   mask = DIV_MASK_4;
      RATIO_32:  mask = DIV_MASK_32;
      RATIO_256: mask = DIV_MASK_256;
      default:   mask = COUNT_ZERO;
    endcase
    st_nxt.pulse = 1'b0;
    // stopped divider restarts its phase, so a run spans whole periods
    if (!run) begin
      st_nxt.div = 8'h00;
    end
    if (run && src_tick) begin
      st_nxt.div   = st_r.div + 8'h01;
      st_nxt.pulse = ((st_r.div & mask) == mask);
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign count_pulse = st_r.pulse;

  // stopped prescaler never emits
  a_pre_idle_stop: assert property (@(posedge clk_sys) disable iff (!resetn)
    !$past(run) |-> !count_pulse) else $error("pulse while stopped");

endmodule

// ==== hdl/dual_reload_down_timer.sv ====
// two 8-bit reload down counters with chaining, event input, toggle output
`timescale 1ns/1ns

// Overview of operation
// - two 8-bit reload counters, optionally one 16-bit
// - chained: channel 0 low byte, 1 high
// - wide mode: run_ch0 controls both counters
// - preset write copies reload into counter
// - run starts, stop holds count value
// - low nibble read latches high nibble
// - underflow reloads, drives flags, toggle, serial clock
// - channel 0 timer mode default; channel 1 timer only
// - event mode counts pin edges, ignores prescaler
// - polarity bit: 0 falling, 1 rising
// - noise reject: accept on second 2048 Hz fall
// - source bit: 0 slow, 1 fast oscillator
// - ratio code 11/10/01/00: 256/32/4/1
// - prescaler runs only while run bit set
// - underflow sets flag; mask gates irq
// - toggle halves chosen channel underflow rate
// - pin carries toggle when enabled, else high
// - enable ungated against toggle, may truncate pulse
// - serial clock from channel 1 toggle, enable-independent
module dual_reload_down_timer
  import reload_timer_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic [3:0] addr,            // register index
  input  wire logic [7:0] wdata,           // write data
  input  wire logic       wr_en,           // write strobe
  input  wire logic       rd_en,           // read strobe
  output logic      [7:0] rdata,           // read data, cycle after strobe
  input  wire logic       slow_tick,       // slow oscillator tick
  input  wire logic       fast_tick,       // fast oscillator tick
  input  wire logic       nr_clk_2048,     // internal 2048 Hz level
  input  wire logic       event_input_pin, // external event level
  output logic            toggle_port_pin, // toggle pin level
  output logic            serial_clk,      // shift clock to serial block
  output logic            irq_ch0,         // interrupt request, channel 0
  output logic            irq_ch1          // interrupt request, channel 1
);
  import reload_timer_pkg::*;

  typedef struct packed {
    logic       wide_chain_select;
    logic       run_ch0;
    logic       run_ch1;
    clk_cfg_t   cfg0;
    clk_cfg_t   cfg1;
    logic       event_mode_select;
    logic       event_edge_polarity;
    logic       noise_reject_enable;
    logic [7:0] reload_value_ch0;
    logic [7:0] reload_value_ch1;
    logic [7:0] count0;
    logic [7:0] count1;
    logic [3:0] hold0;       // latched high nibble, channel 0
    logic [3:0] hold1;       // latched high nibble, channel 1
    logic       underflow_irq_enable_ch0;
    logic       underflow_irq_enable_ch1;
    logic       underflow_flag_ch0;
    logic       underflow_flag_ch1;
    logic       toggle_channel_select;
    logic       toggle_output_enable;
    logic       tog0;        // divide-by-two of channel 0 underflow
    logic       tog1;        // divide-by-two of channel 1 underflow
    logic       ev_level;    // filtered event level
    logic       ev_prev;     // previous filtered level
    logic       nr_prev;     // previous 2048 Hz level
    logic [1:0] nr_cnt;      // falling edges seen since change
    logic [7:0] rdata;
    logic       pin;
    logic       sclk;
    logic       irq0;
    logic       irq1;
  } tmr_state_t;

  tmr_state_t st_r;
  tmr_state_t st_nxt;
  logic       pre0;      // prescaled pulse, channel 0
  logic       pre1;      // prescaled pulse, channel 1
  logic       run1_eff;  // channel 1 run as seen by its prescaler
  logic       ev_edge;   // counting edge of event input
  logic       tick0;     // channel 0 count pulse
  logic       tick1;     // channel 1 count pulse
  logic       uf0;       // channel 0 underflow
  logic       uf1;       // channel 1 underflow
  logic       nr_fall;   // falling edge of 2048 Hz clock
  logic       wr_ctrl;
  logic       wr_flag;

  // wide mode: channel 0 run bit governs both
  assign run1_eff = st_r.wide_chain_select ? st_r.run_ch0
                                           : st_r.run_ch1;

  ratio_prescaler u_pre0 (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .slow_tick   (slow_tick),
    .fast_tick   (fast_tick),
    .cfg         (st_r.cfg0),
    .run         (st_r.run_ch0),
    .count_pulse (pre0)
  );

  ratio_prescaler u_pre1 (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .slow_tick   (slow_tick),
    .fast_tick   (fast_tick),
    .cfg         (st_r.cfg1),
    .run         (run1_eff),
    .count_pulse (pre1)
  );

  // next state: bus, filter, counting, toggles, outputs
  always_comb begin
    st_nxt  = st_r;
    wr_ctrl = wr_en && (addr == REG_CTRL);
    wr_flag = wr_en && (addr == REG_IRQ_FLAG);

    // event filter: bypassed, or accept on second 2048 Hz fall
    nr_fall        = st_r.nr_prev && !nr_clk_2048;
    st_nxt.nr_prev = nr_clk_2048;
    if (!st_r.noise_reject_enable) begin
      st_nxt.ev_level = event_input_pin;
      st_nxt.nr_cnt   = 2'h0;
    end else if (event_input_pin == st_r.ev_level) begin
      st_nxt.nr_cnt = 2'h0; // glitch gone before acceptance
    end else if (nr_fall) begin
      if (st_r.nr_cnt == 2'(NR_EDGES - 1)) begin
        st_nxt.ev_level = event_input_pin;
        st_nxt.nr_cnt   = 2'h0;
      end else begin
        st_nxt.nr_cnt = st_r.nr_cnt + 2'h1;
      end
    end
    st_nxt.ev_prev = st_r.ev_level;
    ev_edge = st_r.event_edge_polarity
            ? (st_r.ev_level && !st_r.ev_prev)  // rising
            : (!st_r.ev_level && st_r.ev_prev); // falling

    // channel 0 clock: event edges or prescaler
    if (st_r.event_mode_select) begin
      tick0 = st_r.run_ch0 && ev_edge;
    end else begin
      // a pulse still in flight at stop is dropped here
      tick0 = st_r.run_ch0 && pre0;
    end
    uf0 = tick0 && (st_r.count0 == COUNT_ZERO);

    // channel 1 clock: own prescaler, or borrow of channel 0
    if (st_r.wide_chain_select) begin
      tick1 = uf0;
    end else begin
      tick1 = run1_eff && pre1;
    end
    uf1 = tick1 && (st_r.count1 == COUNT_ZERO);

    // counters: reload on underflow, hold when not ticking
    // wide mode: low byte borrows through ff, reloads on full underflow
    if (tick0) begin
      st_nxt.count0 = (st_r.wide_chain_select ? uf1 : uf0)
                    ? st_r.reload_value_ch0
                    : st_r.count0 - COUNT_ONE;
    end
    if (tick1) begin
      st_nxt.count1 = uf1 ? st_r.reload_value_ch1
                          : st_r.count1 - COUNT_ONE;
    end

    // toggles: channel 0 only meaningful alone
    if (uf0 && !st_r.wide_chain_select) begin
      st_nxt.tog0 = !st_r.tog0;
    end
    if (uf1) begin
      st_nxt.tog1 = !st_r.tog1;
    end

    // flags: hardware set wins over software clear
    if (wr_flag && wdata[0]) begin
      st_nxt.underflow_flag_ch0 = 1'b0;
    end
    if (wr_flag && wdata[1]) begin
      st_nxt.underflow_flag_ch1 = 1'b0;
    end
    if (uf0 && !st_r.wide_chain_select) begin
      st_nxt.underflow_flag_ch0 = 1'b1;
    end
    if (uf1) begin
      st_nxt.underflow_flag_ch1 = 1'b1;
    end

    // register writes
    if (wr_en) begin
      case (addr)
        REG_CTRL: begin
          st_nxt.wide_chain_select = wdata[CTRL_WIDE];
          st_nxt.run_ch0           = wdata[CTRL_RUN0];
          st_nxt.run_ch1           = wdata[CTRL_RUN1];
        end
        REG_CLKSEL: begin
          st_nxt.cfg0.src   = wdata[CLK_SRC0];
          st_nxt.cfg0.ratio = wdata[CLK_RATIO0+:2];
          st_nxt.cfg1.src   = wdata[CLK_SRC1];
          st_nxt.cfg1.ratio = wdata[CLK_RATIO1+:2];
        end
        REG_EVENT: begin
          st_nxt.event_mode_select   = wdata[EV_MODE];
          st_nxt.event_edge_polarity = wdata[EV_POL];
          st_nxt.noise_reject_enable = wdata[EV_NR];
        end
        REG_RELOAD0: st_nxt.reload_value_ch0 = wdata;
        REG_RELOAD1: st_nxt.reload_value_ch1 = wdata;
        REG_IRQ_EN: begin
          st_nxt.underflow_irq_enable_ch0 = wdata[0];
          st_nxt.underflow_irq_enable_ch1 = wdata[1];
        end
        REG_TOGGLE: begin
          st_nxt.toggle_channel_select = wdata[TG_CHAN];
          st_nxt.toggle_output_enable  = wdata[TG_OE];
        end
        default: ; // flags handled above, rest read-only
      endcase
    end

    // preset strobes beat a same-cycle count
    if (wr_ctrl && wdata[CTRL_PRESET0]) begin
      st_nxt.count0 = st_r.reload_value_ch0;
    end
    if (wr_ctrl && wdata[CTRL_PRESET1]) begin
      st_nxt.count1 = st_r.reload_value_ch1;
    end

    // reads: low nibble read latches high nibble
    st_nxt.rdata = RESET_BYTE;
    if (rd_en) begin
      case (addr)
        REG_CTRL: st_nxt.rdata = {5'h0_0, st_r.run_ch1, st_r.run_ch0,
                                  st_r.wide_chain_select};
        REG_CLKSEL: st_nxt.rdata = {1'b0, st_r.cfg1.ratio, st_r.cfg1.src,
                                    1'b0, st_r.cfg0.ratio, st_r.cfg0.src};
        REG_EVENT: st_nxt.rdata = {5'h0_0, st_r.noise_reject_enable,
                                   st_r.event_edge_polarity,
                                   st_r.event_mode_select};
        REG_RELOAD0: st_nxt.rdata = st_r.reload_value_ch0;
        REG_RELOAD1: st_nxt.rdata = st_r.reload_value_ch1;
        REG_COUNT0_LO: begin
          st_nxt.rdata = {4'h0, st_r.count0[3:0]};
          st_nxt.hold0 = st_r.count0[7:4];
        end
        REG_COUNT0_HI: st_nxt.rdata = {4'h0, st_r.hold0};
        REG_COUNT1_LO: begin
          st_nxt.rdata = {4'h0, st_r.count1[3:0]};
          st_nxt.hold1 = st_r.count1[7:4];
        end
        REG_COUNT1_HI: st_nxt.rdata = {4'h0, st_r.hold1};
        REG_IRQ_EN: st_nxt.rdata = {6'h0_0, st_r.underflow_irq_enable_ch1,
                                    st_r.underflow_irq_enable_ch0};
        REG_IRQ_FLAG: st_nxt.rdata = {6'h0_0, st_r.underflow_flag_ch1,
                                      st_r.underflow_flag_ch0};
        REG_TOGGLE: st_nxt.rdata = {6'h0_0, st_r.toggle_output_enable,
                                    st_r.toggle_channel_select};
        default: st_nxt.rdata = RESET_BYTE; // unmapped reads zero
      endcase
    end

    // outputs; enable not synchronised to toggle, pulses may be cut
    st_nxt.pin = st_r.toggle_output_enable
               ? (st_r.toggle_channel_select ? st_r.tog1 : st_r.tog0)
               : 1'b1;
    st_nxt.sclk = st_r.tog1;
    st_nxt.irq0 = st_r.underflow_flag_ch0 && st_r.underflow_irq_enable_ch0;
    st_nxt.irq1 = st_r.underflow_flag_ch1 && st_r.underflow_irq_enable_ch1;
  end

  // state register; all control bits clear, pin idles high
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_r     <= '0;
      st_r.pin <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata           = st_r.rdata;
  assign toggle_port_pin = st_r.pin;
  assign serial_clk      = st_r.sclk;
  assign irq_ch0         = st_r.irq0;
  assign irq_ch1         = st_r.irq1;

  a_preset_loads_ch0: assert property (@(posedge clk_sys) disable iff (!resetn)
    (wr_en && addr == REG_CTRL && wdata[CTRL_PRESET0])
    |=> st_r.count0 == $past(st_r.reload_value_ch0))
    else $error("preset did not load ch0");
  a_stop_holds_count: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!st_r.run_ch0 && !(wr_en && addr == REG_CTRL)) |=> $stable(st_r.count0))
    else $error("stopped counter moved");
  a_underflow_reload: assert property (@(posedge clk_sys) disable iff (!resetn)
    (uf1 && !(wr_en && addr == REG_CTRL))
    |=> st_r.count1 == $past(st_r.reload_value_ch1))
    else $error("no reload on underflow");
  a_flag_set_uf: assert property (@(posedge clk_sys) disable iff (!resetn)
    uf1 |=> st_r.underflow_flag_ch1)
    else $error("flag not set by underflow");
  a_irq_masked: assert property (@(posedge clk_sys) disable iff (!resetn)
    !st_r.underflow_irq_enable_ch0 |=> !irq_ch0)
    else $error("masked irq raised");
  a_flag_clear_w1: assert property (@(posedge clk_sys) disable iff (!resetn)
    (wr_flag && wdata[0] && !uf0) |=> !st_r.underflow_flag_ch0)
    else $error("flag not cleared");
  a_pin_high_off: assert property (@(posedge clk_sys) disable iff (!resetn)
    !st_r.toggle_output_enable |=> toggle_port_pin)
    else $error("pin not high when disabled");
  a_toggle_flips: assert property (@(posedge clk_sys) disable iff (!resetn)
    uf1 |=> ##1 serial_clk != $past(serial_clk, 1))
    else $error("serial clock did not toggle");
  a_wide_chain_tick: assert property (@(posedge clk_sys) disable iff (!resetn)
    (st_r.wide_chain_select && !uf0 && !(wr_en && addr == REG_CTRL))
    |=> $stable(st_r.count1))
    else $error("high byte moved without borrow");
  a_event_ignores_pre: assert property (@(posedge clk_sys) disable iff (!resetn)
    (st_r.event_mode_select && !ev_edge && !(wr_en && addr == REG_CTRL))
    |=> $stable(st_r.count0))
    else $error("event mode counted without edge");

endmodule

// ==== testbench/osc_event_model.sv ====
// partner model: oscillator ticks, event source, serial clock watcher
`timescale 1ns/1ns
module osc_event_model (
  input  wire logic clk_sys,
  input  wire logic slow_go,         // request one slow tick
  input  wire logic fast_go,         // request one fast tick
  input  wire logic nr_lvl,          // wanted 2048 Hz level
  input  wire logic ev_lvl,          // wanted event level
  input  wire logic serial_clk,      // shift clock from the timer
  output logic      slow_tick,       // slow oscillator tick
  output logic      fast_tick,       // fast oscillator tick
  output logic      nr_clk_2048,     // noise filter clock level
  output logic      event_input_pin, // external event level
  output int        ser_rises        // shift clock rising edges seen
);
  logic ser_q; // last shift clock level, for edge counting

  initial begin
    slow_tick = 1'b0;
    fast_tick = 1'b0;
    nr_clk_2048 = 1'b0;
    event_input_pin = 1'b0;
    ser_q = 1'b0;
    ser_rises = 0;
  end

  // ticks only when asked for, so the oscillators stand still otherwise
  always @(posedge clk_sys) begin
    slow_tick <= slow_go;
    fast_tick <= fast_go;
    nr_clk_2048 <= nr_lvl;
    event_input_pin <= ev_lvl;
    ser_q <= serial_clk;
    // serial side counts only rising shift clock edges
    if (serial_clk && !ser_q) begin
      ser_rises <= ser_rises + 1;
    end
  end
endmodule

// ==== testbench/tb_top.sv ====
// testbench: register access sequences for the dual reload timer
`timescale 1ns/1ns
module tb_top;
  import reload_timer_pkg::*;
  logic       clk_sys, resetn, wr_en, rd_en;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, v;
  logic       slow_go, fast_go, nr_lvl, ev_lvl, p0;
  logic       slow_tick, fast_tick, nr_clk_2048, event_input_pin;
  logic       toggle_port_pin, serial_clk, irq_ch0, irq_ch1;
  int         ser_rises, r0, errors, n_checks, cycles;
  int         div [4] = '{1, 4, 32, 256}; // ratio per code
  logic [3:0] ra [7];                     // registers that reset to zero

  dual_reload_down_timer DUT (.clk_sys(clk_sys), .resetn(resetn),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .slow_tick(slow_tick), .fast_tick(fast_tick),
    .nr_clk_2048(nr_clk_2048), .event_input_pin(event_input_pin),
    .toggle_port_pin(toggle_port_pin), .serial_clk(serial_clk),
    .irq_ch0(irq_ch0), .irq_ch1(irq_ch1));

  osc_event_model far_side (.clk_sys(clk_sys), .slow_go(slow_go),
    .fast_go(fast_go), .nr_lvl(nr_lvl), .ev_lvl(ev_lvl),
    .serial_clk(serial_clk), .slow_tick(slow_tick),
    .fast_tick(fast_tick), .nr_clk_2048(nr_clk_2048),
    .event_input_pin(event_input_pin), .ser_rises(ser_rises));

  // compare and count
  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one-cycle write, one idle cycle so strobes never merge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    @(posedge clk_sys);
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    d = rdata;
    @(posedge clk_sys);
  endtask

  // low part first so the high part is the latched one
  task automatic cnt(input bit ch, output logic [7:0] c);
    logic [7:0] lo, hi;
    rd(ch ? REG_COUNT1_LO : REG_COUNT0_LO, lo);
    rd(ch ? REG_COUNT1_HI : REG_COUNT0_HI, hi);
    c = {hi[3:0], lo[3:0]};
  endtask

  // source ticks spaced two cycles, then let the count path settle
  task automatic tick(input bit fast, input int n);
    repeat (n) begin
      if (fast) fast_go <= 1'b1;
      else slow_go <= 1'b1;
      @(posedge clk_sys);
      fast_go <= 1'b0;
      slow_go <= 1'b0;
      @(posedge clk_sys);
    end
    repeat (6) @(posedge clk_sys);
  endtask

  // one falling edge of the filter clock
  task automatic nr_fall();
    nr_lvl <= 1'b1;
    repeat (3) @(posedge clk_sys);
    nr_lvl <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic ev(input logic l);
    ev_lvl <= l;
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // hang guard, well above the roughly 1700 cycles the run needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end

  initial begin
    {resetn, wr_en, rd_en, slow_go, fast_go, nr_lvl, ev_lvl} = '0;
    addr = 4'h0;
    wdata = 8'h00;
    ra = '{REG_CTRL, REG_CLKSEL, REG_EVENT, REG_IRQ_EN, REG_IRQ_FLAG,
           REG_TOGGLE, 4'hF};
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    // reset state, unmapped index reads zero too
    foreach (ra[i]) begin
      rd(ra[i], v);
      chk("reset reg", v, 16'h0000);
    end
    chk("pin idle", toggle_port_pin, 16'h0001);
    chk("irqs idle", {irq_ch1, irq_ch0, serial_clk}, 16'h0000);
    // preset, run, stop, restart on channel 0, fast source
    wr(REG_CLKSEL, 8'h01);
    wr(REG_RELOAD0, 8'h05);
    wr(REG_CTRL, 8'h08);
    cnt(0, v);
    chk("preset", v, 16'h0005);
    wr(REG_CTRL, 8'h02);
    tick(1, 3);
    tick(0, 2);
    cnt(0, v);
    chk("run fast", v, 16'h0002);
    wr(REG_CTRL, 8'h00);
    tick(1, 4);
    cnt(0, v);
    chk("stopped", v, 16'h0002);
    wr(REG_CTRL, 8'h02);
    tick(1, 1);
    cnt(0, v);
    chk("restart", v, 16'h0001);
    // underflow: reload, flag, mask, clear, toggle
    wr(REG_TOGGLE, 8'h02);
    @(posedge clk_sys);
    p0 = toggle_port_pin;
    tick(1, 2);
    cnt(0, v);
    chk("reload", v, 16'h0005);
    chk("toggle ch0", toggle_port_pin, !p0);
    rd(REG_IRQ_FLAG, v);
    chk("flag set", v, 16'h0001);
    chk("irq masked", irq_ch0, 16'h0000);
    wr(REG_IRQ_FLAG, 8'h00);
    rd(REG_IRQ_FLAG, v);
    chk("flag kept", v, 16'h0001);
    wr(REG_IRQ_EN, 8'h01);
    repeat (2) @(posedge clk_sys);
    chk("irq on", irq_ch0, 16'h0001);
    wr(REG_IRQ_FLAG, 8'h01);
    rd(REG_IRQ_FLAG, v);
    chk("flag clear", {irq_ch0, v}, 16'h0000);
    tick(1, 6);
    chk("toggle back", toggle_port_pin, p0);
    wr(REG_TOGGLE, 8'h00);
    @(posedge clk_sys);
    chk("pin high", toggle_port_pin, 16'h0001);
    wr(REG_CTRL, 8'h00);
    wr(REG_IRQ_EN, 8'h00);
    // serial clock from channel 1, zero reload, enable off
    wr(REG_CLKSEL, 8'h00);
    wr(REG_RELOAD1, 8'h00);
    wr(REG_CTRL, 8'h14);
    p0 = serial_clk;
    r0 = ser_rises;
    tick(0, 1);
    chk("sclk flip", serial_clk, !p0);
    tick(0, 1);
    chk("sclk rises", 16'(ser_rises - r0), 16'h0001);
    // channel 0 flag still pending from its second underflow
    rd(REG_IRQ_FLAG, v);
    chk("flag ch1", v, 16'h0003);
    wr(REG_IRQ_EN, 8'h02);
    @(posedge clk_sys);
    chk("irq ch1", {irq_ch1, irq_ch0}, 16'h0002);
    wr(REG_IRQ_EN, 8'h00);
    wr(REG_TOGGLE, 8'h03);
    @(posedge clk_sys);
    p0 = toggle_port_pin;
    tick(0, 1);
    chk("toggle ch1", toggle_port_pin, !p0);
    wr(REG_CTRL, 8'h00);
    wr(REG_TOGGLE, 8'h00);
    wr(REG_IRQ_FLAG, 8'h03);
    // every prescaler ratio, one tick short and then exact
    for (int k = 0; k < 4; k++) begin
      wr(REG_CLKSEL, {1'b0, k[1:0], 5'h00});
      wr(REG_RELOAD1, 8'h40);
      wr(REG_CTRL, 8'h10);
      wr(REG_CTRL, 8'h04);
      tick(0, 2 * div[k] - 1);
      cnt(1, v);
      chk("ratio short", v, 16'h003f);
      tick(0, 1);
      cnt(1, v);
      chk("ratio full", v, 16'h003e);
      wr(REG_CTRL, 8'h00);
    end
    // high nibble held from the low read across a borrow
    wr(REG_CLKSEL, 8'h01);
    wr(REG_RELOAD0, 8'h10);
    wr(REG_CTRL, 8'h0a);
    rd(REG_COUNT0_LO, v);
    chk("lo nibble", v, 16'h0000);
    tick(1, 1);
    rd(REG_COUNT0_HI, v);
    chk("held hi", v, 16'h0001);
    cnt(0, v);
    chk("after borrow", v, 16'h000f);
    // sixteen-bit chain, run bit of channel 0 drives both
    wr(REG_RELOAD0, 8'h00);
    wr(REG_RELOAD1, 8'h01);
    wr(REG_CTRL, 8'h19);
    wr(REG_CTRL, 8'h03);
    tick(1, 1);
    cnt(0, v);
    chk("wide low", v, 16'h00ff);
    cnt(1, v);
    chk("wide high", v, 16'h0000);
    wr(REG_CTRL, 8'h01);
    tick(1, 1);
    cnt(0, v);
    chk("wide stop", v, 16'h00ff);
    // event counting, both polarities, prescaler ignored
    wr(REG_RELOAD0, 8'h20);
    wr(REG_CTRL, 8'h08);
    wr(REG_EVENT, 8'h01);
    wr(REG_CTRL, 8'h02);
    tick(1, 3);
    ev(1'b1);
    cnt(0, v);
    chk("ev ignore", v, 16'h0020);
    ev(1'b0);
    cnt(0, v);
    chk("ev fall", v, 16'h001f);
    wr(REG_EVENT, 8'h03);
    ev(1'b1);
    ev(1'b0);
    cnt(0, v);
    chk("ev rise", v, 16'h001e);
    // noise filter: short glitch dropped, held level taken late
    wr(REG_EVENT, 8'h07);
    ev(1'b1);
    nr_fall();
    ev(1'b0);
    nr_fall();
    nr_fall();
    cnt(0, v);
    chk("glitch", v, 16'h001e);
    ev(1'b1);
    nr_fall();
    cnt(0, v);
    chk("one fall", v, 16'h001e);
    nr_fall();
    cnt(0, v);
    chk("two falls", v, 16'h001d);
    summarize();
  end
endmodule
